// ### verilog/ubdii_pkg.sv
// Constants, types and helpers shared by the divisor and interrupt-id block
package ubdii_pkg;

	// Register byte addresses (one aligned word each)
	localparam logic [31:0] ADDR_DATA = 32'he000c000;
	localparam logic [31:0] ADDR_IER  = 32'he000c004;
	localparam logic [31:0] ADDR_IIR  = 32'he000c008;

	// Reset values
	localparam logic [7:0] DLL_RST = 8'h01;
	localparam logic [7:0] DLM_RST = 8'h00;
	localparam logic [2:0] IER_RST = 3'h0;
	localparam logic [7:0] IIR_RST = 8'h01;

	// Field positions
	localparam int IER_RDA_BIT  = 0;
	localparam int IER_TRANSMIT_HOLDING_EMPTY_BIT = 1;
	localparam int IER_RLS_BIT  = 2;
	localparam int IIR_PEND_BIT = 0;
	localparam int IER_W        = 3;

	// AHB-Lite encodings
	localparam logic [2:0] SIZE_WORD = 3'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;

	// Character time-out: ((wl*7-2)*8) + ((trig-held)*8+1) sampling clocks
	localparam int          TO_W      = 11;
	localparam logic [10:0] TO_WL_MIN = 11'h005;
	localparam logic [10:0] TO_MUL    = 11'h007;
	localparam logic [10:0] TO_SUB    = 11'h002;
	localparam logic [10:0] TO_CHAR   = 11'h008;
	localparam logic [10:0] TO_ONE    = 11'h001;

	// Oversampling ratio of the baud sampling clock
	localparam int OVERSAMPLE = 16;

	typedef enum logic [2:0] {
		ID_NONE = 3'b000,
		ID_TRANSMIT_HOLDING_EMPTY = 3'b001,
		ID_RDA  = 3'b010,
		ID_RLS  = 3'b011,
		ID_CTI  = 3'b110
	} ubdii_id_e;

	// Receive side status from the FIFO and shift logic
	typedef struct packed {
		logic [4:0] level;    // Characters held in receive FIFO
		logic [1:0] trig;     // Trigger select, fifo control bits 7:6
		logic [1:0] word_len; // Line control word length select
		logic       push;     // New character written into FIFO
		logic [3:0] err;      // {break, framing, parity, overrun} events
	} ubdii_rx_s;

	function automatic logic [4:0] trig_chars(input logic [1:0] t);
		logic [4:0] r;
		r = 5'h01;
		case (t)
			2'h0: r = 5'h01;
			2'h1: r = 5'h04;
			2'h2: r = 5'h08;
			2'h3: r = 5'h0e;
		endcase
		return r;
	endfunction

endpackage

// ### verilog/ubdii_baud_gen.sv
// Divisor-driven generator of the 16x baud sampling tick
`timescale 1ns/1ps
`default_nettype none
module ubdii_baud_gen #(
	parameter int DIV_W = 16
) (
	input  wire logic             clk_i,     // Peripheral clock
	input  wire logic             rst_n_i,   // Sync reset, active low
	input  wire logic             ce_i,      // Clock enable
	input  wire logic [DIV_W-1:0] divisor_i, // Programmed divisor
	output logic                  tick_o     // One-cycle sampling tick
);
	logic [DIV_W-1:0] cnt_q;
	logic [DIV_W-1:0] eff;

	if (DIV_W < 2) begin : g_bad_width
		$error("ubdii_baud_gen: DIV_W must be at least 2");
	end

	// A zero divisor acts as one so the counter never stalls
	assign eff = (divisor_i == '0) ? DIV_W'(1) : divisor_i; // [RQ3]

	// Counter restarts early if software shrinks the divisor mid-count
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt_q  <= '0;
			tick_o <= 1'b0;
		end else if (ce_i) begin
			if (cnt_q >= eff - DIV_W'(1)) begin // [RQ1]
				cnt_q  <= '0;
				tick_o <= 1'b1;
			end else begin
				cnt_q  <= cnt_q + DIV_W'(1);
				tick_o <= 1'b0;
			end
		end
	end

	property p_div_zero;
		@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && divisor_i == '0 |=> tick_o;
	endproperty
	a_div_zero: assert property (p_div_zero) // [RQ3]
		else $error("zero divisor did not tick every cycle");

	property p_div_two;
		@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && tick_o && divisor_i == DIV_W'(2) && cnt_q == '0 ##1
		ce_i && divisor_i == DIV_W'(2) |=> tick_o;
	endproperty
	a_div_two: assert property (p_div_two) // [RQ1]
		else $error("divisor of two gave wrong tick spacing");

endmodule
`default_nettype wire

// ### verilog/ubdii_top.sv
// Baud divisor, interrupt enable and identification with AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RQ1] Divide clock by divisor for 16x sampling tick
// [RQ2] Divisor is high byte over low byte
// [RQ3] Zero divisor divides by one
// [RQ4] Divisor bytes reachable only with access bit set
// [RQ5] Enable bit 0 gates data and time-out
// [RQ6] Enable bit 1 gates holding empty; status out
// [RQ7] Enable bit 2 gates line errors; flags out
// [RQ8] Pending bit active low, resets to one
// [RQ9] Codes 011 errors, 010 data, 110 time-out
// [RQ10] Code 001 holding empty; others never produced
// [RQ11] Bits 7:6 mirror FIFO enable, reset zero
// [RQ12] Identification frozen during its read
// [RQ13] Line errors first; data and time-out second
// [RQ14] Errors raise interrupt; status read clears
// [RQ15] Data interrupt while fill at trigger level
// [RQ16] Time-out after idle with characters held
// [RQ17] Any receive FIFO activity clears time-out
// [RQ18] Software reads identification before leaving handler
// [RQ19] Access bit is line control bit 7
// [RQ20] Holding empty third; write or id read clears
// [RQ21] Time-out length from word length and fill
// [RQ22] Disabled sources hidden; highest enabled reported
module ubdii_top #(
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic                clk_i,        // Peripheral clock
	input  wire logic                rst_n_i,      // Sync reset, active low
	input  wire logic                ce_i,         // Clock enable
	input  wire logic                hsel_i,       // AHB slave select
	input  wire logic [31:0]         haddr_i,      // AHB address
	input  wire logic [1:0]          htrans_i,     // AHB transfer type
	input  wire logic                hwrite_i,     // AHB write
	input  wire logic [2:0]          hsize_i,      // AHB size
	input  wire logic [31:0]         hwdata_i,     // AHB write data
	input  wire logic                hready_i,     // AHB bus ready
	output logic      [31:0]         hrdata_o,     // AHB read data
	output logic                     hreadyout_o,  // AHB slave ready
	output logic      [1:0]          hresp_o,      // AHB response
	input  wire logic                divisor_access_bit_i,       // Line control bit 7
	input  wire logic                fifo_en_i,    // FIFO control bit 0
	input  wire ubdii_pkg::ubdii_rx_s rx_i,        // Receive FIFO status
	input  wire logic [7:0]          rx_data_i,    // Oldest receive byte
	input  wire logic                lsr_read_i,   // Line status read pulse
	input  wire logic                thr_empty_i,  // Transmit FIFO empty
	output logic                     rbr_read_o,   // Receive byte popped
	output logic                     thr_write_o,  // Transmit byte pushed
	output logic      [7:0]          thr_data_o,   // Transmit byte
	output logic      [3:0]          lsr_err_o,    // Status bits 4:1
	output logic                     transmit_holding_empty_o,       // Status bit 5
	output logic                     baud_tick_o,  // 16x sampling tick
	output logic                     irq_o         // Interrupt request
);
	import ubdii_pkg::*;

	if (FIFO_DEPTH < 14 || FIFO_DEPTH > 31) begin : g_bad_depth
		$error("ubdii_top: FIFO_DEPTH must lie in 14..31");
	end

	// Bus decode
	logic        acc;
	logic        rd_a;
	logic        wr_a;
	logic        rd_data;
	logic        rd_ier;
	logic        rd_iir;
	logic        wr_q;
	logic [31:0] waddr_q;
	logic        wdlab_q;
	logic        wr_dll;
	logic        wr_dlm;
	logic        wr_ier;
	logic        thr_wr;
	logic [31:0] hrdata_d;

	// Registers
	logic [7:0]       dll_q;
	logic [7:0]       dlm_q;
	logic [IER_W-1:0] ier_q;
	logic [7:0]       iir_q;
	logic [7:0]       iir_d;

	// Sources
	logic        rx_act;
	logic        rda_q;
	logic        cti_q;
	logic        transmit_holding_empty_int_q;
	logic        transmit_holding_empty_prev_q;
	logic        transmit_holding_empty_rise;
	logic        transmit_holding_empty_clr;
	logic [10:0] cti_cnt_q;
	logic [10:0] to_target;
	logic        tick;
	logic        en_rls;
	logic        en_rda;
	logic        en_cti;
	logic        en_transmit_holding_empty;
	logic        pend;
	ubdii_id_e   id;

	assign acc  = hsel_i & htrans_i[1] & hready_i & (hsize_i == SIZE_WORD);
	assign rd_a = acc & ~hwrite_i;
	assign wr_a = acc & hwrite_i;
	assign rd_data = rd_a & (haddr_i == ADDR_DATA);
	assign rd_ier  = rd_a & (haddr_i == ADDR_IER);
	assign rd_iir  = rd_a & (haddr_i == ADDR_IIR);

	// Writes complete in the data phase; access bit is taken at address
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wr_q    <= 1'b0;
			waddr_q <= 32'h0;
			wdlab_q <= 1'b0;
		end else if (ce_i) begin
			wr_q <= wr_a;
			if (wr_a) begin
				waddr_q <= haddr_i;
				wdlab_q <= divisor_access_bit_i; // [RQ19]
			end
		end
	end

	assign wr_dll = wr_q & (waddr_q == ADDR_DATA) & wdlab_q; // [RQ4]
	assign thr_wr = wr_q & (waddr_q == ADDR_DATA) & ~wdlab_q;
	assign wr_dlm = wr_q & (waddr_q == ADDR_IER) & wdlab_q;  // [RQ4]
	assign wr_ier = wr_q & (waddr_q == ADDR_IER) & ~wdlab_q;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			dll_q <= DLL_RST;
			dlm_q <= DLM_RST;
			ier_q <= IER_RST;
		end else if (ce_i) begin
			if (wr_dll) begin
				dll_q <= hwdata_i[7:0];
			end
			if (wr_dlm) begin
				dlm_q <= hwdata_i[7:0];
			end
			if (wr_ier) begin
				ier_q <= hwdata_i[IER_W-1:0];
			end
		end
	end

	// Read data is registered at the address phase; zero wait states
	always_comb begin
		hrdata_d = 32'h0;
		if (rd_data) begin
			hrdata_d = {24'h0, divisor_access_bit_i ? dll_q : rx_data_i}; // [RQ4]
		end else if (rd_ier) begin
			hrdata_d = divisor_access_bit_i ? {24'h0, dlm_q} : {29'h0, ier_q};
		end else if (rd_iir) begin
			hrdata_d = {24'h0, iir_q};
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			hrdata_o    <= 32'h0;
			hreadyout_o <= 1'b1;
			hresp_o     <= RESP_OKAY;
		end else if (ce_i) begin
			hrdata_o    <= hrdata_d;
			hreadyout_o <= 1'b1;
			hresp_o     <= RESP_OKAY;
		end
	end

	// Strobes towards the FIFO logic
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rbr_read_o  <= 1'b0;
			thr_write_o <= 1'b0;
			thr_data_o  <= 8'h0;
			transmit_holding_empty_o      <= 1'b0;
		end else if (ce_i) begin
			rbr_read_o  <= rd_data & ~divisor_access_bit_i;
			thr_write_o <= thr_wr;
			transmit_holding_empty_o      <= thr_empty_i; // [RQ6]
			if (thr_wr) begin
				thr_data_o <= hwdata_i[7:0];
			end
		end
	end

	ubdii_baud_gen #(
		.DIV_W     (16)
	) u_baud (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n_i),
		.ce_i      (ce_i),
		.divisor_i ({dlm_q, dll_q}), // [RQ2]
		.tick_o    (tick)
	);
	assign baud_tick_o = tick;

	// Line errors: a new event in the clearing cycle survives
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			lsr_err_o <= 4'h0;
		end else if (ce_i) begin
			lsr_err_o <= rx_i.err | (lsr_read_i ? 4'h0 : lsr_err_o); // [RQ14]
		end
	end

	// Data available follows the fill level; single-byte mode uses one
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rda_q <= 1'b0;
		end else if (ce_i) begin
			if (fifo_en_i) begin
				rda_q <= rx_i.level >= trig_chars(rx_i.trig); // [RQ15]
			end else begin
				rda_q <= rx_i.level != 5'h0;
			end
		end
	end

	// Time-out length in sampling ticks; eight fewer per held character, floor of one
	always_comb begin
		logic [10:0] wl;
		logic [10:0] tot;
		logic [10:0] sub;
		wl  = 11'(rx_i.word_len) + TO_WL_MIN;
		tot = (wl * TO_MUL - TO_SUB) * TO_CHAR
			+ 11'(trig_chars(rx_i.trig)) * TO_CHAR + TO_ONE; // [RQ21]
		sub = 11'(rx_i.level) * TO_CHAR;
		to_target = (tot > sub) ? tot - sub : TO_ONE;
	end

	assign rx_act = rx_i.push | (rd_data & ~divisor_access_bit_i);

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cti_cnt_q <= 11'h0;
			cti_q     <= 1'b0;
		end else if (ce_i) begin
			if (rx_act || rx_i.level == 5'h0) begin
				cti_cnt_q <= 11'h0;
				cti_q     <= 1'b0; // [RQ17]
			end else if (tick) begin
				if (cti_cnt_q + TO_ONE >= to_target) begin
					cti_q <= 1'b1; // [RQ16]
				end else begin
					cti_cnt_q <= cti_cnt_q + TO_ONE;
				end
			end
		end
	end

	// Holding empty raised on the empty edge; set beats clear
	assign transmit_holding_empty_rise = thr_empty_i & ~transmit_holding_empty_prev_q;
	assign transmit_holding_empty_clr  = thr_wr | (rd_iir && iir_q[3:1] == ID_TRANSMIT_HOLDING_EMPTY); // [RQ20]

	// Starts as empty so that leaving reset raises no holding-empty edge
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			transmit_holding_empty_prev_q <= 1'b1;
			transmit_holding_empty_int_q  <= 1'b0;
		end else if (ce_i) begin
			transmit_holding_empty_prev_q <= thr_empty_i;
			if (transmit_holding_empty_rise) begin
				transmit_holding_empty_int_q <= 1'b1;
			end else if (transmit_holding_empty_clr) begin
				transmit_holding_empty_int_q <= 1'b0;
			end
		end
	end

	// Gating and priority
	assign en_rls  = ier_q[IER_RLS_BIT] & (|lsr_err_o);  // [RQ7]
	assign en_rda  = ier_q[IER_RDA_BIT] & rda_q;        // [RQ5]
	assign en_cti  = ier_q[IER_RDA_BIT] & cti_q;        // [RQ5]
	assign en_transmit_holding_empty = ier_q[IER_TRANSMIT_HOLDING_EMPTY_BIT] & transmit_holding_empty_int_q;  // [RQ6]
	assign pend    = en_rls | en_rda | en_cti | en_transmit_holding_empty; // [RQ22]

	always_comb begin
		if (en_rls) begin
			id = ID_RLS; // [RQ13]
		end else if (en_rda) begin
			id = ID_RDA; // [RQ9]
		end else if (en_cti) begin
			id = ID_CTI; // [RQ9]
		end else if (en_transmit_holding_empty) begin
			id = ID_TRANSMIT_HOLDING_EMPTY; // [RQ10]
		end else begin
			id = ID_NONE;
		end
	end

	assign iir_d = {{2{fifo_en_i}}, 2'b00, id, ~pend}; // [RQ8] [RQ11]

	// Snapshot held across the read; sources keep updating meanwhile
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			iir_q <= IIR_RST;
			irq_o <= 1'b0;
		end else if (ce_i) begin
			irq_o <= pend;
			if (!rd_iir) begin
				iir_q <= iir_d; // [RQ12]
			end
		end
	end

	property p_dll_locked;
		@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && wr_q && waddr_q == ADDR_DATA && !wdlab_q |=> $stable(dll_q);
	endproperty
	a_dll_locked: assert property (p_dll_locked) // [RQ4]
		else $error("divisor low changed with access bit clear");

	property p_pend_low;
		@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && !rd_iir |=> iir_q[IIR_PEND_BIT] == !$past(pend);
	endproperty
	a_pend_low: assert property (p_pend_low) // [RQ8]
		else $error("pending bit does not track enabled sources");

	property p_rls_first;
		@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && !rd_iir && en_rls |=> iir_q[3:1] == ID_RLS;
	endproperty
	a_rls_first: assert property (p_rls_first) // [RQ13]
		else $error("line status not reported first");

	property p_freeze;
		@(posedge clk_i) disable iff (!rst_n_i)
		rd_iir |=> $stable(iir_q);
	endproperty
	a_freeze: assert property (p_freeze) // [RQ12]
		else $error("identification changed during its read");

	property p_transmit_holding_empty_clear;
		@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && thr_wr && !transmit_holding_empty_rise |=> !transmit_holding_empty_int_q;
	endproperty
	a_transmit_holding_empty_clear: assert property (p_transmit_holding_empty_clear) // [RQ20]
		else $error("holding write did not clear empty interrupt");

	property p_err_clear;
		@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && lsr_read_i && rx_i.err == 4'h0 |=> lsr_err_o == 4'h0;
	endproperty
	a_err_clear: assert property (p_err_clear) // [RQ14]
		else $error("status read did not clear error flags");

	property p_cti_act;
		@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && rx_act |=> !cti_q && cti_cnt_q == 11'h0;
	endproperty
	a_cti_act: assert property (p_cti_act) // [RQ17]
		else $error("receive activity did not clear time-out");

	property p_rda_level;
		@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && fifo_en_i && rx_i.level >= trig_chars(rx_i.trig) |=> rda_q;
	endproperty
	a_rda_level: assert property (p_rda_level) // [RQ15]
		else $error("trigger level reached without data interrupt");

	property p_fifo_bits;
		@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && !rd_iir |=> iir_q[7:6] == {2{$past(fifo_en_i)}};
	endproperty
	a_fifo_bits: assert property (p_fifo_bits) // [RQ11]
		else $error("fifo enable bits wrong in identification");

endmodule
`default_nettype wire

// ### sim/ubdii_rx_partner.sv
// Behavioural receive FIFO, line error source and transmit-empty flag
`timescale 1ns/1ps
`default_nettype none
module ubdii_rx_partner (
	input  wire logic            clk_i,   // Peripheral clock
	input  wire logic            rd_i,    // Receive byte popped
	input  wire logic [1:0]      trig_i,  // Trigger select
	input  wire logic [1:0]      wl_i,    // Word length select
	output ubdii_pkg::ubdii_rx_s rx_o,    // Receive FIFO status
	output logic      [7:0]      data_o,  // Oldest byte
	output logic                 empty_o  // Transmit FIFO empty
);
	import ubdii_pkg::*;
	logic [7:0] q[$];
	logic [4:0] lvl = 5'h00;
	logic       push = 1'b0;
	logic [3:0] err = 4'h0;
	initial empty_o = 1'b0;
	initial data_o = 8'h00;
	assign rx_o = '{level: lvl, trig: trig_i, word_len: wl_i,
		push: push, err: err};
	// An empty FIFO shows the inverse of the last byte, never a stale one
	always @(posedge clk_i) begin
		if (rd_i && q.size() > 0) begin
			void'(q.pop_front());
			lvl <= lvl - 5'h01;
			data_o <= (q.size() > 0) ? q[0] : ~data_o;
		end
	end
	task automatic send(input logic [7:0] d);
		@(posedge clk_i);
		q.push_back(d);
		push <= 1'b1;
		lvl <= lvl + 5'h01;
		data_o <= q[0];
		@(posedge clk_i);
		push <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
	task automatic line_err(input int b);
		@(posedge clk_i);
		err <= 4'h1 << b;
		@(posedge clk_i);
		err <= 4'h0;
		repeat (4) @(posedge clk_i);
	endtask
	task automatic set_empty(input logic v);
		@(posedge clk_i);
		empty_o <= v;
		repeat (4) @(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// ### sim/ubdii_top_tb.sv
// Self-checking bench for the divisor and interrupt identification block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin \
	num_errors++; $display("BAD %s exp %h got %h", nm, e, s); end end
module ubdii_top_tb;
	import ubdii_pkg::*;
	logic        clk, rst_n, hsel, hwrite, divisor_access_bit, fifo_en, lsr_rd, hready;
	logic        rbr_rd, thr_wr, transmit_holding_empty, tick, irq, empty, ce;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans, hresp, trig, wl;
	logic [2:0]  hsize;
	logic [7:0]  thr_data, rx_data;
	logic [3:0]  lsr_err;
	ubdii_rx_s   rx;
	int          num_errors = 0;
	int          n_tests = 0;
	int          n;

	ubdii_top DUT (.clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
		.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.divisor_access_bit_i(divisor_access_bit), .fifo_en_i(fifo_en), .rx_i(rx), .rx_data_i(rx_data),
		.lsr_read_i(lsr_rd), .thr_empty_i(empty), .rbr_read_o(rbr_rd),
		.thr_write_o(thr_wr), .thr_data_o(thr_data), .lsr_err_o(lsr_err),
		.transmit_holding_empty_o(transmit_holding_empty), .baud_tick_o(tick), .irq_o(irq));
	ubdii_rx_partner P (.clk_i(clk), .rd_i(rbr_rd), .trig_i(trig),
		.wl_i(wl), .rx_o(rx), .data_o(rx_data), .empty_o(empty));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic end_of_test;
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Address phase held until hready, then data phase until hready again
	task automatic bus(input logic [31:0] a, input logic w,
		input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		rd = hrdata;
		`CHK("hresp", RESP_OKAY, hresp)
	endtask
	task automatic rdc(input logic [31:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		`CHK("hrdata", e, rd)
	endtask
	task automatic set_lines(input logic dl, input logic fe);
		@(posedge clk);
		divisor_access_bit <= dl;
		fifo_en <= fe;
	endtask
	task automatic ticks(input int cyc, input int e);
		repeat (cyc) @(posedge clk);
		n = 0;
		repeat (cyc) begin
			@(posedge clk);
			if (tick === 1'b1)
				n++;
		end
		`CHK("ticks", e, n)
	endtask
	task automatic lsr_pulse;
		@(posedge clk);
		lsr_rd <= 1'b1;
		@(posedge clk);
		lsr_rd <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	initial begin
		#100000;
		num_errors++;
		end_of_test();
	end

	initial begin
		{rst_n, hsel, hwrite, divisor_access_bit, fifo_en, lsr_rd} = 6'h00;
		ce = 1'b1;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'h0;
		hsize = SIZE_WORD;
		trig = 2'h3;
		wl = 2'h0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rdc(ADDR_IIR, 32'h01);
		rdc(ADDR_IER, 32'h00);
		set_lines(1'b1, 1'b0);
		rdc(ADDR_DATA, 32'h01);
		rdc(ADDR_IER, 32'h00);
		bus(ADDR_DATA, 1'b1, 32'h0);
		ticks(20, 20);
		bus(ADDR_IER, 1'b1, 32'h1);
		rdc(ADDR_IER, 32'h01);
		ticks(520, 2);
		bus(ADDR_IER, 1'b1, 32'h0);
		bus(ADDR_DATA, 1'b1, 32'h3);
		ticks(30, 10);
		bus(ADDR_DATA, 1'b1, 32'h2);
		ticks(30, 15);
		// A transfer taken while the clock enable is low is lost
		ce <= 1'b0;
		bus(ADDR_DATA, 1'b1, 32'h77);
		ce <= 1'b1;
		rdc(ADDR_DATA, 32'h02);
		bus(ADDR_DATA, 1'b1, 32'h1);
		set_lines(1'b0, 1'b0);
		bus(ADDR_IER, 1'b1, 32'h4);
		rdc(ADDR_IER, 32'h04);
		rdc(32'he000c010, 32'h0);
		hsize <= 3'h0;
		rdc(ADDR_IER, 32'h0);
		hsize <= SIZE_WORD;
		bus(ADDR_IIR, 1'b1, 32'hff);
		for (int b = 0; b < 4; b++) begin
			P.line_err(b);
			`CHK("lsr_err", 4'h1 << b, lsr_err)
			rdc(ADDR_IIR, 32'h06);
			lsr_pulse();
			rdc(ADDR_IIR, 32'h01);
		end
		bus(ADDR_IER, 1'b1, 32'h0);
		P.send(8'h3c);
		P.line_err(0);
		rdc(ADDR_IIR, 32'h01);
		`CHK("irq", 1'b0, irq)
		bus(ADDR_IER, 1'b1, 32'h7);
		repeat (3) @(posedge clk);
		rdc(ADDR_IIR, 32'h06);
		`CHK("irq", 1'b1, irq)
		lsr_pulse();
		rdc(ADDR_IIR, 32'h04);
		rdc(ADDR_DATA, 32'h3c);
		`CHK("rbr_rd", 1'b1, rbr_rd)
		repeat (3) @(posedge clk);
		rdc(ADDR_IIR, 32'h01);
		P.set_empty(1'b1);
		`CHK("transmit_holding_empty", 1'b1, transmit_holding_empty)
		rdc(ADDR_IIR, 32'h02);
		rdc(ADDR_IIR, 32'h01);
		P.set_empty(1'b0);
		P.set_empty(1'b1);
		bus(ADDR_DATA, 1'b1, 32'h5a);
		// Strobe and byte come out one edge after the data phase
		@(posedge clk);
		`CHK("thr_wr", 1'b1, thr_wr)
		`CHK("thr_data", 8'h5a, thr_data)
		repeat (3) @(posedge clk);
		rdc(ADDR_IIR, 32'h01);
		set_lines(1'b0, 1'b1);
		P.send(8'h11);
		rdc(ADDR_IIR, 32'hc1);
		// Seven edges have passed since the push was taken
		n = 7;
		while (irq !== 1'b1 && n < 800) begin
			@(posedge clk);
			n++;
		end
		`CHK("cti_time", 1'b1, (n >= 369 && n <= 376))
		rdc(ADDR_IIR, 32'hcc);
		wl <= 2'h3;
		P.send(8'h22);
		rdc(ADDR_IIR, 32'hc1);
		// Eight-bit words, two held: 432 + 97 sampling ticks
		n = 7;
		while (irq !== 1'b1 && n < 800) begin
			@(posedge clk);
			n++;
		end
		`CHK("cti_wl", 1'b1, (n >= 529 && n <= 536))
		rdc(ADDR_IIR, 32'hcc);
		rdc(ADDR_DATA, 32'h11);
		rdc(ADDR_IIR, 32'hc1);
		rdc(ADDR_DATA, 32'h22);
		trig <= 2'h0;
		P.send(8'h33);
		rdc(ADDR_IIR, 32'hc4);
		rdc(ADDR_DATA, 32'h33);
		repeat (3) @(posedge clk);
		rdc(ADDR_IIR, 32'hc1);
		end_of_test();
	end
endmodule
`default_nettype wire
